// ---- design/hb_if.sv ----
// Link between the core and the output float timer
`timescale 1ns/1ps
interface hb_if;
    logic start;
    logic busy;
    modport timer (input start, output busy);
    modport ctrl  (output start, input busy);
endinterface

// ---- design/hb_timer.sv ----
// Output float timer started after each burst outside ST_STRAP
`timescale 1ns/1ps
module hb_timer #(
    parameter touch_pkg::hb_cnt_t HB_CYCLES = 16'h7530
) (
    // Clock and reset
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    // Control link
    hb_if.timer       hb
);
    import touch_pkg::*;

    hb_cnt_t cnt;
    hb_cnt_t next_cnt;
    logic    busy;
    logic    next_busy;

    assign hb.busy = busy;

    // Reload on every burst, count down while floating
    always_comb begin
        next_cnt  = cnt;
        next_busy = busy;
        if (hb.start) begin
            next_cnt  = HB_CYCLES - 16'h0001;
            next_busy = 1'b1;
        end else if (busy) begin
            if (cnt == 16'h0000) begin
                next_busy = 1'b0;
            end else begin
                next_cnt = cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt  <= 16'h0000;
            busy <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            busy <= next_busy;
        end
    end

    sequence s_float_hold;
        busy [*8];
    endsequence

    AST_HB_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        hb.start |=> s_float_hold)
        else $error("float window shorter than expected");

    AST_HB_END: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        busy && cnt == 16'h0000 && !hb.start |=> !busy)
        else $error("float window did not end");
endmodule // hb_timer

// ---- design/touch_cfg.svh ----
// Constants of the touch detection core, with the notes on behaviour
// Notes on behaviour
// - Signal, reference, threshold and counters use 16-bit arithmetic, except the 33-bit max-on counter.
// - Reference drifts toward signal only when not detecting; frozen during detection.
// - Reference moves one count per step; threshold and hysteresis follow it.
// - Reference follows a falling signal faster than a rising one.
// - Gain strap high gives threshold 6 counts, low gives 12 counts.
// - Detection releases below threshold minus 17% of threshold-reference delta.
// - Each hit burst increments integrator; output activates at count 3.
// - A miss before the final count clears the integrator at once.
// - Detection longer than finite max-on duration forces full recalibration.
// - Max-on durations are 10 s, 60 s or infinite.
// - No recalibration input; recalibration only at power-up or timeout.
// - Straps sampled once after power-up; later changes ignored.
// - DC mode: output low while detecting; inactive after timeout recalibration.
// - Toggle mode: each detection inverts output; 10 s timeout keeps state.
// - Mode straps: 11 DC 10 s, 10 DC 60 s, 00 toggle, 01 DC infinite.
// - Output floats for 300 us once after every burst; bursts in ST_STRAP start no float.
`ifndef TOUCH_CFG_SVH
`define TOUCH_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define HB_TIME_US      300
`define MAXON_SHORT_S   10
`define MAXON_LONG_S    60
`define NS_PER_S        64'h0000_0000_3b9a_ca00
`define NS_PER_US       1000

// ----------------------------------------------------------------------
// Arithmetic
// ----------------------------------------------------------------------
`define THR_HIGH        16'h0006
`define THR_LOW         16'h000c
`define HYST_PCT        32'h0000_0011
`define PCT_SCALE       32'h0000_0064
`define INTEG_LIMIT     16'h0003
`define DRIFT_DN_BURSTS 16'h0002
`define DRIFT_UP_BURSTS 16'h0010
`define WORD_MAX        16'hffff
`define STRAP_SETTLE    2'h3

`endif

// ---- design/touch_detect_processing.sv ----
// Touch detection core: drift tracking, threshold, integrator, timeout, output
`timescale 1ns/1ps
`include "touch_cfg.svh"
module touch_detect_processing #(
    parameter touch_pkg::hb_cnt_t  HB_CYCLES =
        16'((`HB_TIME_US * `NS_PER_US) / `CLK_PERIOD_NS),
    parameter touch_pkg::on_cnt_t  MAXON_SHORT_CYCLES =
        33'((`MAXON_SHORT_S * `NS_PER_S) / `CLK_PERIOD_NS),
    parameter touch_pkg::on_cnt_t  MAXON_LONG_CYCLES =
        33'((`MAXON_LONG_S * `NS_PER_S) / `CLK_PERIOD_NS)
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             rst_n_i,
    // Burst results from the converter
    input  wire logic             burst_valid_i,
    input  wire touch_pkg::word_t burst_signal_i,
    // Option straps
    input  wire logic             gain_strap_i,
    input  wire logic             mode_strap_a_i,
    input  wire logic             mode_strap_b_i,
    // Detect output pin and status
    output logic                  detect_out_o,
    output logic                  detect_oe_n_o,
    output logic                  calibrating_o
);
    import touch_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic [1:0] rst_sync;
    logic       rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Saturating addition for threshold levels
    function automatic word_t sat_add(input word_t a, input word_t b);
        logic [16:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[16] ? `WORD_MAX : sum[15:0];
    endfunction

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic [1:0] strap_wait;
    logic [1:0] next_strap_wait;
    logic       strap_done;
    logic       next_strap_done;
    logic       gain_hi;
    logic       next_gain_hi;
    mode_t      mode;
    mode_t      next_mode;

    // Straps are latched once, after the synchroniser settles
    always_comb begin
        next_strap_wait = strap_wait;
        next_strap_done = strap_done;
        next_gain_hi    = gain_hi;
        next_mode       = mode;
        if (!strap_done) begin
            if (strap_wait == `STRAP_SETTLE) begin
                next_strap_done = 1'b1;
                next_gain_hi    = strap_sync[0];
                next_mode       = mode_t'(strap_sync[2:1]);
            end else begin
                next_strap_wait = strap_wait + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_meta <= 3'h0;
            strap_sync <= 3'h0;
            strap_wait <= 2'h0;
            strap_done <= 1'b0;
            gain_hi    <= 1'b0;
            mode       <= MODE_DC_10;
        end else begin
            strap_meta <= {mode_strap_a_i, mode_strap_b_i, gain_strap_i};
            strap_sync <= strap_meta;
            strap_wait <= next_strap_wait;
            strap_done <= next_strap_done;
            gain_hi    <= next_gain_hi;
            mode       <= next_mode;
        end
    end

    // ------------------------------------------------------------------
    // Detection core
    // ------------------------------------------------------------------
    state_t  state;
    state_t  next_state;
    word_t   ref_lvl;
    word_t   next_ref_lvl;
    word_t   integ;
    word_t   next_integ;
    word_t   drift_cnt;
    word_t   next_drift_cnt;
    on_cnt_t on_cnt;
    on_cnt_t next_on_cnt;
    logic    detecting;
    logic    next_detecting;
    logic    toggle_state;
    logic    next_toggle_state;
    word_t   thr;
    word_t   hyst;
    word_t   trip_lvl;
    word_t   release_lvl;
    logic    hit;
    logic    timeout;
    on_cnt_t max_on;

    // Threshold and hysteresis ride on the reference
    always_comb begin
        thr         = gain_hi ? `THR_HIGH : `THR_LOW;
        hyst        = word_t'((32'(thr) * `HYST_PCT) / `PCT_SCALE);
        trip_lvl    = sat_add(ref_lvl, thr);
        release_lvl = sat_add(ref_lvl, thr - hyst);
        hit         = burst_signal_i >= trip_lvl;
        max_on      = (mode == MODE_DC_60) ? MAXON_LONG_CYCLES : MAXON_SHORT_CYCLES;
        timeout     = detecting && mode != MODE_DC_INF && on_cnt >= max_on;
    end

    // Calibration, drift, integrator and timeout
    always_comb begin
        next_state        = state;
        next_ref_lvl      = ref_lvl;
        next_integ        = integ;
        next_drift_cnt    = drift_cnt;
        next_on_cnt       = on_cnt;
        next_detecting    = detecting;
        next_toggle_state = toggle_state;
        case (state)
            ST_STRAP: begin
                if (strap_done) begin
                    next_state = ST_CAL;
                end
            end
            ST_CAL: begin
                if (burst_valid_i) begin
                    next_ref_lvl   = burst_signal_i;
                    next_integ     = 16'h0000;
                    next_drift_cnt = 16'h0000;
                    next_state     = ST_RUN;
                end
            end
            ST_RUN: begin
                if (timeout) begin
                    next_detecting = 1'b0;
                    next_integ     = 16'h0000;
                    next_on_cnt    = 33'h0;
                    next_state     = ST_CAL;
                end else if (detecting) begin
                    next_on_cnt = on_cnt + 33'h1;
                    if (burst_valid_i && burst_signal_i < release_lvl) begin
                        next_detecting = 1'b0;
                        next_integ     = 16'h0000;
                    end
                end else if (burst_valid_i) begin
                    if (hit) begin
                        next_integ = integ + 16'h0001;
                        if (integ == `INTEG_LIMIT - 16'h0001) begin
                            next_detecting = 1'b1;
                            next_on_cnt    = 33'h0;
                            if (mode == MODE_TOGGLE) begin
                                next_toggle_state = ~toggle_state;
                            end
                        end
                    end else begin
                        next_integ = 16'h0000;
                    end
                    // Slow drift only while idle, faster downward
                    if (burst_signal_i < ref_lvl) begin
                        if (drift_cnt >= `DRIFT_DN_BURSTS - 16'h0001) begin
                            next_ref_lvl   = ref_lvl - 16'h0001;
                            next_drift_cnt = 16'h0000;
                        end else begin
                            next_drift_cnt = drift_cnt + 16'h0001;
                        end
                    end else if (burst_signal_i > ref_lvl) begin
                        if (drift_cnt >= `DRIFT_UP_BURSTS - 16'h0001) begin
                            next_ref_lvl   = ref_lvl + 16'h0001;
                            next_drift_cnt = 16'h0000;
                        end else begin
                            next_drift_cnt = drift_cnt + 16'h0001;
                        end
                    end else begin
                        next_drift_cnt = 16'h0000;
                    end
                end
            end
            default: begin
                next_state = ST_STRAP;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state        <= ST_STRAP;
            ref_lvl      <= 16'h0000;
            integ        <= 16'h0000;
            drift_cnt    <= 16'h0000;
            on_cnt       <= 33'h0;
            detecting    <= 1'b0;
            toggle_state <= 1'b0;
        end else begin
            state        <= next_state;
            ref_lvl      <= next_ref_lvl;
            integ        <= next_integ;
            drift_cnt    <= next_drift_cnt;
            on_cnt       <= next_on_cnt;
            detecting    <= next_detecting;
            toggle_state <= next_toggle_state;
        end
    end

    // ------------------------------------------------------------------
    // Output pin
    // ------------------------------------------------------------------
    hb_if  hb_bus ();
    logic  next_out;

    assign hb_bus.start = burst_valid_i && state != ST_STRAP;

    hb_timer #(
        .HB_CYCLES (HB_CYCLES)
    ) u_hb_timer (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n),
        .hb         (hb_bus.timer)
    );

    // Active-low detect level per output mode
    always_comb begin
        next_out = (mode == MODE_TOGGLE) ? ~toggle_state : ~detecting;
    end

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            detect_out_o  <= 1'b1;
            detect_oe_n_o <= 1'b0;
            calibrating_o <= 1'b1;
        end else begin
            detect_out_o  <= next_out;
            detect_oe_n_o <= hb_bus.busy;
            calibrating_o <= next_state != ST_RUN;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_idle_miss;
        state == ST_RUN && !detecting && !timeout && burst_valid_i && !hit;
    endsequence

    sequence s_hold_detect;
        state == ST_RUN && detecting && !timeout;
    endsequence

    AST_REF_FROZEN: assert property (s_hold_detect |=> ref_lvl == $past(ref_lvl))
        else $error("reference moved during detection");

    AST_REF_SLEW: assert property ($past(state) == ST_RUN && state == ST_RUN |->
        (ref_lvl == $past(ref_lvl) || ref_lvl == $past(ref_lvl) + 16'h0001 ||
         ref_lvl == $past(ref_lvl) - 16'h0001))
        else $error("reference step larger than one count");

    AST_REF_DOWN_CAUSE: assert property (state == ST_RUN && ref_lvl < $past(ref_lvl) |->
        $past(burst_signal_i) < $past(ref_lvl))
        else $error("reference fell without a lower signal");

    AST_INTEG_CLEAR: assert property (s_idle_miss |=> integ == 16'h0000)
        else $error("integrator not cleared on miss");

    AST_DETECT_CAUSE: assert property ($rose(detecting) |->
        $past(integ) == (`INTEG_LIMIT - 16'h0001) && $past(hit) && $past(burst_valid_i))
        else $error("detection without three hits");

    AST_HYST_HOLD: assert property ((s_hold_detect and (burst_valid_i &&
        burst_signal_i >= release_lvl)) |=> detecting)
        else $error("detection released above hysteresis level");

    AST_TIMEOUT: assert property (timeout && state == ST_RUN |=>
        state == ST_CAL && !detecting)
        else $error("timeout did not recalibrate");

    AST_INFINITE: assert property (mode == MODE_DC_INF && state == ST_RUN |=>
        state == ST_RUN)
        else $error("recalibration in infinite mode");

    AST_DC_OUT: assert property (mode != MODE_TOGGLE && strap_done |=>
        detect_out_o == !$past(detecting))
        else $error("dc output does not follow detection");

    AST_TOGGLE: assert property (mode == MODE_TOGGLE && $rose(detecting) |=>
        detect_out_o != $past(detect_out_o))
        else $error("toggle output did not invert");

    AST_STRAP_HOLD: assert property (strap_done |=> $stable(mode) && $stable(gain_hi))
        else $error("straps changed after capture");

    AST_HB_PIN: assert property (burst_valid_i && state != ST_STRAP |->
        ##2 detect_oe_n_o)
        else $error("output not floated after burst");
endmodule // touch_detect_processing

// ---- design/touch_pkg.sv ----
// Types shared by the touch detection core
package touch_pkg;
    typedef logic [15:0] word_t;
    typedef logic [32:0] on_cnt_t;
    typedef logic [15:0] hb_cnt_t;

    typedef enum logic [1:0] {
        ST_STRAP = 2'b00,
        ST_CAL   = 2'b01,
        ST_RUN   = 2'b10
    } state_t;

    // Encoded exactly as {mode_strap_a, mode_strap_b}
    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_DC_INF = 2'b01,
        MODE_DC_60  = 2'b10,
        MODE_DC_10  = 2'b11
    } mode_t;
endpackage

// ---- tb/electrode_model.sv ----
// Partner model: electrode with converter front end, and the output load
`timescale 1ns/1ps
module electrode_model (
    // Clock
    input  wire logic             core_clk_i,
    // Bench commands
    input  wire logic             fire_i,
    input  wire touch_pkg::word_t level_i,
    // Burst results towards the core
    output logic                  burst_valid_o,
    output touch_pkg::word_t      burst_signal_o,
    // Output pin seen through a pull-down load
    input  wire logic             detect_out_i,
    input  wire logic             detect_oe_n_i,
    output logic                  pin_o
);
    import touch_pkg::*;

    // Known levels before the first edge
    initial begin
        burst_valid_o = 1'b0;
        burst_signal_o = 16'h0000;
    end

    // One-cycle burst result; the data bus toggles when no result is offered
    always @(posedge core_clk_i) begin
        burst_valid_o <= fire_i;
        burst_signal_o <= fire_i ? level_i : ~burst_signal_o;
    end

    // Floating pin falls to the pull-down level
    assign pin_o = detect_oe_n_i ? 1'b0 : detect_out_i;
endmodule // electrode_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the touch detection core
`timescale 1ns/1ps
module tb_top;
    import touch_pkg::*;

    // ------------------------------------------------------------------
    // Shortened counts and stimulus levels
    // ------------------------------------------------------------------
    localparam hb_cnt_t HB      = 16'h0008;
    localparam on_cnt_t T_SHORT = 33'h0_0000_0032;
    localparam on_cnt_t T_LONG  = 33'h0_0000_0064;
    localparam word_t   BASE    = 16'h03e8;

    logic   core_clk_i;
    logic   rst_n_i;
    logic   fire;
    word_t  level;
    logic   gain_strap_i;
    logic   mode_strap_a_i;
    logic   mode_strap_b_i;
    logic   burst_valid_i;
    word_t  burst_signal_i;
    logic   detect_out_o;
    logic   detect_oe_n_o;
    logic   calibrating_o;
    logic   pin;
    int     miscompares;
    int     n_compared;

    // Design and far-side model
    touch_detect_processing #(
        .HB_CYCLES          (HB),
        .MAXON_SHORT_CYCLES (T_SHORT),
        .MAXON_LONG_CYCLES  (T_LONG)
    ) dut_u (
        .core_clk_i     (core_clk_i),
        .rst_n_i        (rst_n_i),
        .burst_valid_i  (burst_valid_i),
        .burst_signal_i (burst_signal_i),
        .gain_strap_i   (gain_strap_i),
        .mode_strap_a_i (mode_strap_a_i),
        .mode_strap_b_i (mode_strap_b_i),
        .detect_out_o   (detect_out_o),
        .detect_oe_n_o  (detect_oe_n_o),
        .calibrating_o  (calibrating_o)
    );
    electrode_model model_u (
        .core_clk_i     (core_clk_i),
        .fire_i         (fire),
        .level_i        (level),
        .burst_valid_o  (burst_valid_i),
        .burst_signal_o (burst_signal_i),
        .detect_out_i   (detect_out_o),
        .detect_oe_n_i  (detect_oe_n_o),
        .pin_o          (pin)
    );

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // ------------------------------------------------------------------
    // Compare, report and drive helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish();
        if (miscompares == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            miscompares++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    // n burst results through the model, each followed by a quiet cycle
    task automatic burst(input word_t v, input int n);
        repeat (n) begin
            @(posedge core_clk_i);
            fire <= 1'b1;
            level <= v;
            @(posedge core_clk_i);
            fire <= 1'b0;
        end
    endtask

    // Supply cycle with new strap levels, then the calibrating burst
    task automatic power_up(input logic g, input logic a, input logic b);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        gain_strap_i <= g;
        mode_strap_a_i <= a;
        mode_strap_b_i <= b;
        tick(5);
        chk_bit("detect_out_o in reset", 1'b1, detect_out_o);
        chk_bit("detect_oe_n_o in reset", 1'b0, detect_oe_n_o);
        chk_bit("calibrating_o in reset", 1'b1, calibrating_o);
        @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        tick(12);
        burst(BASE, 1);
        tick(3);
        chk_bit("calibrating_o after first burst", 1'b0, calibrating_o);
    endtask

    // Three bursts at one level, then the output has settled
    task automatic try_detect(input string what, input word_t v, input logic exp);
        burst(v, 3);
        tick(4);
        chk_bit(what, exp, detect_out_o);
    endtask

    // Cycles from now until the timeout recalibration shows
    task automatic wait_timeout(input int lo, input int hi);
        int n;
        n = 0;
        while (calibrating_o !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        chk_range("timeout cycles", lo, hi, n);
        // Output flop follows one edge after the state change
        tick(1);
        if (n == 300) begin
            tally_and_finish();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_integrator_dc10();
        power_up(1'b1, 1'b1, 1'b1);
        try_detect("just under high gain threshold", BASE + 16'h0005, 1'b1);
        burst(BASE + 16'h0006, 2);
        burst(BASE + 16'h0005, 1);
        burst(BASE + 16'h0006, 2);
        tick(4);
        chk_bit("miss clears integrator", 1'b1, detect_out_o);
        gain_strap_i <= 1'b0;
        burst(BASE + 16'h0006, 1);
        tick(4);
        chk_bit("third hit activates", 1'b0, detect_out_o);
        wait_timeout(int'(T_SHORT) - 5, int'(T_SHORT) + 5);
        chk_bit("dc output after timeout", 1'b1, detect_out_o);
        burst(BASE + 16'h0014, 1);
        tick(3);
        chk_bit("recalibrated", 1'b0, calibrating_o);
        try_detect("old level misses new ref", BASE + 16'h0019, 1'b1);
    endtask

    task automatic sc_hysteresis_inf();
        int n;
        int m;
        power_up(1'b1, 1'b0, 1'b1);
        // Let the calibration float window run out first
        tick(int'(HB));
        burst(BASE, 1);
        #1;
        n = 0;
        while (detect_oe_n_o !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk_bit("pin pulled down while floating", 1'b0, pin);
        m = 0;
        while (detect_oe_n_o === 1'b1 && m < 100) begin
            tick(1);
            m++;
        end
        chk_range("float start", 2, 2, n);
        chk_range("float length", int'(HB), int'(HB) + 1, m);
        try_detect("detect at threshold", BASE + 16'h0006, 1'b0);
        burst(BASE + 16'h001e, 20);
        burst(BASE + 16'h0005, 1);
        tick(4);
        chk_bit("held inside hysteresis", 1'b0, detect_out_o);
        burst(BASE + 16'h0004, 1);
        tick(4);
        chk_bit("released below hysteresis", 1'b1, detect_out_o);
        try_detect("reference frozen while detecting", BASE + 16'h0006, 1'b0);
        tick(int'(T_LONG) + 50);
        chk_bit("infinite keeps detection", 1'b0, detect_out_o);
        chk_bit("infinite no recalibration", 1'b0, calibrating_o);
    endtask

    task automatic sc_low_gain();
        power_up(1'b0, 1'b1, 1'b1);
        try_detect("just under low gain threshold", BASE + 16'h000b, 1'b1);
        try_detect("low gain threshold", BASE + 16'h000c, 1'b0);
        burst(BASE + 16'h000a, 1);
        tick(4);
        chk_bit("held inside low gain hysteresis", 1'b0, detect_out_o);
        burst(BASE + 16'h0009, 1);
        tick(4);
        chk_bit("released low gain", 1'b1, detect_out_o);
    endtask

    task automatic sc_drift();
        power_up(1'b1, 1'b1, 1'b1);
        burst(BASE - 16'h000a, 4);
        try_detect("reference fell quickly", BASE + 16'h0004, 1'b0);
        power_up(1'b1, 1'b1, 1'b1);
        burst(BASE + 16'h0003, 8);
        try_detect("reference rose slowly", BASE + 16'h0006, 1'b0);
    endtask

    task automatic sc_toggle();
        power_up(1'b1, 1'b0, 1'b0);
        try_detect("toggle on", BASE + 16'h0006, 1'b0);
        wait_timeout(int'(T_SHORT) - 5, int'(T_SHORT) + 5);
        chk_bit("toggle kept on timeout", 1'b0, detect_out_o);
        burst(BASE, 2);
        tick(3);
        chk_bit("toggle recalibrated", 1'b0, calibrating_o);
        try_detect("toggle off", BASE + 16'h0006, 1'b1);
    endtask

    task automatic sc_dc60();
        power_up(1'b1, 1'b1, 1'b0);
        try_detect("dc60 detect", BASE + 16'h0006, 1'b0);
        wait_timeout(int'(T_LONG) - 5, int'(T_LONG) + 5);
        chk_bit("dc60 output after timeout", 1'b1, detect_out_o);
    endtask

    // Main sequence
    initial begin
        miscompares = 0;
        n_compared = 0;
        rst_n_i = 1'b0;
        fire = 1'b0;
        level = 16'h0000;
        gain_strap_i = 1'b1;
        mode_strap_a_i = 1'b1;
        mode_strap_b_i = 1'b1;
        sc_integrator_dc10();
        sc_hysteresis_inf();
        sc_low_gain();
        sc_drift();
        sc_toggle();
        sc_dc60();
        tally_and_finish();
    end

    // Overall hang guard
    initial begin
        repeat (50000) @(posedge core_clk_i);
        miscompares++;
        tally_and_finish();
    end
endmodule // tb_top
